// File: hdl/pcg_pkg.sv
// Shared constants for the peripheral clock gating block, set one.
// Assumes a 12-bit register offset space on the system control port.
package pcg_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] PCG_RUN_OFF = 12'h104;
	localparam logic [11:0] PCG_SLP_OFF = 12'h114;
	localparam logic [11:0] PCG_DSL_OFF = 12'h124;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam logic [31:0] PCG_RESET   = 32'h0000_0000;
	localparam logic [31:0] PCG_WR_MASK = 32'h070f_5037;
	localparam int          PCG_UNITS   = 14;

	// Unit index to bit position in every gating register
	localparam logic [4:0] PCG_BIT_ASYNC0 = 5'h00;
	localparam logic [4:0] PCG_BIT_ASYNC1 = 5'h01;
	localparam logic [4:0] PCG_BIT_ASYNC2 = 5'h02;
	localparam logic [4:0] PCG_BIT_SYNC0  = 5'h04;
	localparam logic [4:0] PCG_BIT_SYNC1  = 5'h05;
	localparam logic [4:0] PCG_BIT_TWO0   = 5'h0c;
	localparam logic [4:0] PCG_BIT_TWO1   = 5'h0e;
	localparam logic [4:0] PCG_BIT_GPC0   = 5'h10;
	localparam logic [4:0] PCG_BIT_GPC1   = 5'h11;
	localparam logic [4:0] PCG_BIT_GPC2   = 5'h12;
	localparam logic [4:0] PCG_BIT_GPC3   = 5'h13;
	localparam logic [4:0] PCG_BIT_CMP0   = 5'h18;
	localparam logic [4:0] PCG_BIT_CMP1   = 5'h19;
	localparam logic [4:0] PCG_BIT_CMP2   = 5'h1a;

	localparam logic [4:0] PCG_UNIT_BIT [PCG_UNITS] = '{
		PCG_BIT_ASYNC0, PCG_BIT_ASYNC1, PCG_BIT_ASYNC2,
		PCG_BIT_SYNC0, PCG_BIT_SYNC1, PCG_BIT_TWO0, PCG_BIT_TWO1,
		PCG_BIT_GPC0, PCG_BIT_GPC1, PCG_BIT_GPC2, PCG_BIT_GPC3,
		PCG_BIT_CMP0, PCG_BIT_CMP1, PCG_BIT_CMP2};

	// ----------------------------------------------------------------
	// Power modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PCG_MODE_RUN,
		PCG_MODE_SLEEP,
		PCG_MODE_DEEP
	} pcg_mode_t;

endpackage

// File: hdl/pcg_gate_cell.sv
// One unit's clock enable: picks the run bit, or with auto_sel on the bit of the current mode,
// and registers it. Assumes a clock gate cell downstream.
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_cell
	import pcg_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_sys,
	input  wire logic      rst_n,
	// Gating bits of the three registers
	input  wire logic      run_bit,
	input  wire logic      slp_bit,
	input  wire logic      dsl_bit,
	// Mode selection
	input  wire logic      auto_sel,
	input  wire pcg_mode_t mode,
	// Registered enable
	output logic           en
);

	typedef struct packed {
		logic en;
	} pcg_cell_t;

	pcg_cell_t st_r;
	pcg_cell_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Run bits rule unless automatic gating is on outside run mode
		if (!auto_sel || mode == PCG_MODE_RUN) begin
			st_nxt.en = run_bit;
		end else if (mode == PCG_MODE_SLEEP) begin
			st_nxt.en = slp_bit;
		end else begin
			st_nxt.en = dsl_bit;
		end
	end

	// Registered so the enable only moves right after an edge,
	// which keeps the downstream gate free of glitches.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign en = st_r.en;

endmodule
`default_nettype wire

// File: hdl/pcg_gate_ctrl.sv
// Peripheral clock gating, set one: three gating registers and the
// per-unit clock enables and access fault checks.
// Assumes a single-cycle register port and synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_ctrl
	import pcg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Register port
	input  wire logic        reg_req,
	input  wire logic        reg_wr,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_ack,
	// Mode inputs
	input  wire logic        auto_gating_select,
	input  wire pcg_mode_t   pwr_mode,
	// Peripheral access check
	input  wire logic        per_req,
	input  wire logic [3:0]  per_unit,
	output logic             per_fault,
	output logic             per_ok,
	// Unit clock enables
	output logic             async_port0_gate,
	output logic             async_port1_gate,
	output logic             async_port2_gate,
	output logic             sync_serial0_gate,
	output logic             sync_serial1_gate,
	output logic             two_wire0_gate,
	output logic             two_wire1_gate,
	output logic             gp_counter0_gate,
	output logic             gp_counter1_gate,
	output logic             gp_counter2_gate,
	output logic             gp_counter3_gate,
	output logic             analog_cmp0_gate,
	output logic             analog_cmp1_gate,
	output logic             analog_cmp2_gate
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] run_gate;
		logic [31:0] slp_gate;
		logic [31:0] dsl_gate;
		logic [31:0] rdata;
		logic        ack;
	} pcg_state_t;

	pcg_state_t st_r;
	pcg_state_t st_nxt;

	logic [PCG_UNITS-1:0] unit_en;
	logic                 unit_hit;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt     = st_r;
		st_nxt.ack = reg_req;
		if (reg_req && reg_wr) begin
			// Reserved positions ignore writes
			if (reg_addr == PCG_RUN_OFF) begin
				st_nxt.run_gate = reg_wdata & PCG_WR_MASK;
			end else if (reg_addr == PCG_SLP_OFF) begin
				st_nxt.slp_gate = reg_wdata & PCG_WR_MASK;
			end else if (reg_addr == PCG_DSL_OFF) begin
				st_nxt.dsl_gate = reg_wdata & PCG_WR_MASK;
			end
		end
		if (reg_req && !reg_wr) begin
			if (reg_addr == PCG_RUN_OFF) begin
				st_nxt.rdata = st_r.run_gate & PCG_WR_MASK;
			end else if (reg_addr == PCG_SLP_OFF) begin
				st_nxt.rdata = st_r.slp_gate & PCG_WR_MASK;
			end else if (reg_addr == PCG_DSL_OFF) begin
				st_nxt.rdata = st_r.dsl_gate & PCG_WR_MASK;
			end else begin
				// Unmapped offsets read as zero
				st_nxt.rdata = PCG_RESET;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r.run_gate <= PCG_RESET;
			st_r.slp_gate <= PCG_RESET;
			st_r.dsl_gate <= PCG_RESET;
			st_r.rdata    <= PCG_RESET;
			st_r.ack      <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign reg_ack   = st_r.ack;

	// ----------------------------------------------------------------
	// Unit enables
	// ----------------------------------------------------------------
	for (genvar u = 0; u < PCG_UNITS; u++) begin : g_unit
		pcg_gate_cell u_cell (
			.clk_sys  (clk_sys),
			.rst_n    (rst_n),
			.run_bit  (st_r.run_gate[PCG_UNIT_BIT[u]]),
			.slp_bit  (st_r.slp_gate[PCG_UNIT_BIT[u]]),
			.dsl_bit  (st_r.dsl_gate[PCG_UNIT_BIT[u]]),
			.auto_sel (auto_gating_select),
			.mode     (pwr_mode),
			.en       (unit_en[u])
		);
	end

	assign async_port0_gate  = unit_en[0];
	assign async_port1_gate  = unit_en[1];
	assign async_port2_gate  = unit_en[2];
	assign sync_serial0_gate = unit_en[3];
	assign sync_serial1_gate = unit_en[4];
	assign two_wire0_gate    = unit_en[5];
	assign two_wire1_gate    = unit_en[6];
	assign gp_counter0_gate  = unit_en[7];
	assign gp_counter1_gate  = unit_en[8];
	assign gp_counter2_gate  = unit_en[9];
	assign gp_counter3_gate  = unit_en[10];
	assign analog_cmp0_gate  = unit_en[11];
	assign analog_cmp1_gate  = unit_en[12];
	assign analog_cmp2_gate  = unit_en[13];

	// ----------------------------------------------------------------
	// Access check
	// ----------------------------------------------------------------
	// Unit indices past the last unit have no clock and always fault
	assign unit_hit  = (int'(per_unit) < PCG_UNITS) ?
		unit_en[per_unit] : 1'b0;
	assign per_fault = per_req && !unit_hit;
	assign per_ok    = per_req && unit_hit;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [PCG_UNITS-1:0] src_sel;
	logic [PCG_UNITS-1:0] run_map;
	logic [PCG_UNITS-1:0] slp_map;

	always_comb begin
		src_sel = '0;
		run_map = '0;
		slp_map = '0;
		for (int i = 0; i < PCG_UNITS; i++) begin
			run_map[i] = st_r.run_gate[PCG_UNIT_BIT[i]];
			slp_map[i] = st_r.slp_gate[PCG_UNIT_BIT[i]];
			if (!auto_gating_select || pwr_mode == PCG_MODE_RUN) begin
				src_sel[i] = st_r.run_gate[PCG_UNIT_BIT[i]];
			end else if (pwr_mode == PCG_MODE_SLEEP) begin
				src_sel[i] = st_r.slp_gate[PCG_UNIT_BIT[i]];
			end else begin
				src_sel[i] = st_r.dsl_gate[PCG_UNIT_BIT[i]];
			end
		end
	end

	reset_clear_a: assert property (@(posedge clk_sys)
		$rose(rst_n) |-> unit_en == '0 && st_r.run_gate == '0)
		else $error("unit enables not clear after reset");

	unit_follow_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		$past(rst_n) |-> unit_en == $past(src_sel))
		else $error("unit enable does not follow selected bit");

	fault_gate_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		per_req |-> (per_fault != per_ok) &&
			(per_fault == !(per_unit < 4'hE && unit_en[per_unit])))
		else $error("fault answer disagrees with unit enable");

	run_rules_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		$past(rst_n) && $past(!auto_gating_select) |->
			unit_en == $past(run_map))
		else $error("run gating not applied without auto select");

	deep_read_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && !reg_wr && reg_addr == 12'h124 |=>
			reg_ack && reg_rdata == $past(st_r.dsl_gate))
		else $error("deep-sleep register readback wrong");

	sleep_wr_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr && reg_addr == 12'h114 |=>
			st_r.slp_gate == ($past(reg_wdata) & 32'h070f_5037))
		else $error("sleep register write lost");

	rsvd_zero_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_ack |-> (reg_rdata & 32'hf8f0_afc8) == 32'h0)
		else $error("reserved bits read nonzero");

	timer_bits_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr && reg_addr == 12'h104 &&
		!auto_gating_select ##1 !auto_gating_select |=>
			gp_counter3_gate == $past(reg_wdata[19], 2) &&
			gp_counter0_gate == $past(reg_wdata[16], 2))
		else $error("counter gate not on its run bit");

	serial_bits_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr && reg_addr == 12'h104 &&
		!auto_gating_select ##1 !auto_gating_select |=>
			two_wire1_gate == $past(reg_wdata[14], 2) &&
			sync_serial0_gate == $past(reg_wdata[4], 2) &&
			async_port2_gate == $past(reg_wdata[2], 2))
		else $error("serial unit gate not on its run bit");

	cmp_bits_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr && reg_addr == 12'h104 &&
		!auto_gating_select ##1 !auto_gating_select |=>
			analog_cmp2_gate == $past(reg_wdata[26], 2) &&
			analog_cmp0_gate == $past(reg_wdata[24], 2) &&
			async_port0_gate == $past(reg_wdata[0], 2))
		else $error("comparator gate not on its run bit");

	ack_pulse_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_ack == $past(reg_req))
		else $error("register answer not one cycle after request");

	run_write_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr && reg_addr == 12'h104 |=>
			st_r.run_gate == ($past(reg_wdata) & 32'h070f_5037))
		else $error("run register write lost");

	deep_write_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr && reg_addr == 12'h124 |=>
			st_r.dsl_gate == ($past(reg_wdata) & 32'h070f_5037))
		else $error("deep-sleep register write lost");

	rsvd_store_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr |=> ((st_r.run_gate | st_r.slp_gate |
			st_r.dsl_gate) & 32'hf8f0_afc8) == 32'h0)
		else $error("reserved bit stored a written one");

	unmapped_write_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr && reg_addr != 12'h104 &&
		reg_addr != 12'h114 && reg_addr != 12'h124 |=>
			$stable(st_r.run_gate) && $stable(st_r.slp_gate) &&
			$stable(st_r.dsl_gate))
		else $error("write to unmapped offset changed a register");

	sleep_apply_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		$past(rst_n) && $past(auto_gating_select) &&
		$past(pwr_mode) == PCG_MODE_SLEEP |-> unit_en == $past(slp_map))
		else $error("sleep gating not applied with auto select");

	deep_sleep_c: cover property (@(posedge clk_sys)
		disable iff (!rst_n)
		auto_gating_select && pwr_mode == PCG_MODE_DEEP ##1 |unit_en);

	fault_seen_c: cover property (@(posedge clk_sys)
		disable iff (!rst_n)
		per_fault ##2 per_ok);

	sleep_read_c: cover property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && !reg_wr && reg_addr == PCG_SLP_OFF ##1 reg_rdata != '0);

	sleep_apply_c: cover property (@(posedge clk_sys)
		disable iff (!rst_n)
		auto_gating_select && pwr_mode == PCG_MODE_SLEEP ##1
			unit_en != '0);

	run_enable_c: cover property (@(posedge clk_sys)
		disable iff (!rst_n)
		reg_req && reg_wr && reg_addr == PCG_RUN_OFF ##2 |unit_en);

endmodule
`default_nettype wire

// File: sim/pcg_cpu_model.sv
// Processor-side model of the register port: one access per xfer call, a read then a write per rmw_set call.
// Assumes its tasks are called from one bench process at a time.
`timescale 1ns/1ps
`default_nettype none
module pcg_cpu_model (
	// Clock
	input  wire logic        clk_sys,
	// Register port
	output logic             reg_req,
	output logic             reg_wr,
	output logic      [11:0] reg_addr,
	output logic      [31:0] reg_wdata,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_ack
);
	initial begin
		reg_req = 1'h0;
		reg_wr = 1'h0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0000_0000;
	end
	// ----------------------------------------------------------------
	// Accesses
	// ----------------------------------------------------------------
	// Request is taken at the next edge and the answer is registered,
	// so it is read just after that edge. Idle lines carry junk.
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ak);
		@(posedge clk_sys);
		#1;
		reg_req = 1'h1;
		reg_wr = wr;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#1;
		ak = reg_ack;
		q = reg_rdata;
		reg_req = 1'h0;
		reg_wr = ~wr;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// Enable units before use, keeping reserved bits as read
	task automatic rmw_set(input logic [11:0] a, input logic [31:0] b,
		output logic ak);
		logic [31:0] q;
		logic        k;
		xfer(1'h0, a, 32'h0000_0000, q, k);
		xfer(1'h1, a, q | b, q, ak);
		ak = ak & k;
	endtask
endmodule
`default_nettype wire

// File: sim/peripheral_clock_gating_set1_tb.sv
// Self-checking bench for the clock gating block, set one.
// Assumes the register port model drives all register inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
 errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module peripheral_clock_gating_set1_tb;
	import pcg_pkg::*;
	logic clk_sys, rst_n, reg_req, reg_wr, reg_ack, auto_gating_select;
	logic per_req, per_fault, per_ok, ak;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, q, gv;
	logic [3:0] per_unit;
	pcg_mode_t pwr_mode;
	logic async_port0_gate, async_port1_gate, async_port2_gate;
	logic sync_serial0_gate, sync_serial1_gate;
	logic two_wire0_gate, two_wire1_gate;
	logic gp_counter0_gate, gp_counter1_gate;
	logic gp_counter2_gate, gp_counter3_gate;
	logic analog_cmp0_gate, analog_cmp1_gate, analog_cmp2_gate;
	int errors, samples_checked;
	logic [11:0] offs [3] = '{12'h104, 12'h114, 12'h124};
	int ub [14] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25, 26};
	assign gv = {5'h00, analog_cmp2_gate, analog_cmp1_gate,
		analog_cmp0_gate, 4'h0, gp_counter3_gate, gp_counter2_gate,
		gp_counter1_gate, gp_counter0_gate, 1'h0, two_wire1_gate, 1'h0,
		two_wire0_gate, 6'h00, sync_serial1_gate, sync_serial0_gate,
		1'h0, async_port2_gate, async_port1_gate, async_port0_gate};
	pcg_cpu_model i_cpu (.clk_sys, .reg_req, .reg_wr, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_ack);
	pcg_gate_ctrl i_dut (.clk_sys, .rst_n, .reg_req, .reg_wr, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_ack, .auto_gating_select, .pwr_mode,
		.per_req, .per_unit, .per_fault, .per_ok, .async_port0_gate,
		.async_port1_gate, .async_port2_gate, .sync_serial0_gate,
		.sync_serial1_gate, .two_wire0_gate, .two_wire1_gate,
		.gp_counter0_gate, .gp_counter1_gate, .gp_counter2_gate,
		.gp_counter3_gate, .analog_cmp0_gate, .analog_cmp1_gate,
		.analog_cmp2_gate);
	initial begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_cpu.xfer(1'h1, a, d, q, ak);
		`CHK(ak, 1'h1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		i_cpu.xfer(1'h0, a, 32'h0000_0000, q, ak);
		`CHK(ak, 1'h1);
		`CHK(q, e);
	endtask
	task automatic pchk(input logic [3:0] u, input logic ok);
		// Request stands over one edge so the fault check sees it
		per_unit = u;
		per_req = 1'h1;
		#1;
		`CHK(per_ok, ok);
		`CHK(per_fault, !ok);
		@(posedge clk_sys);
		#1;
		per_req = 1'h0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic t_reset;
		for (int i = 0; i < 3; i++) rd(offs[i], 32'h0000_0000);
		`CHK(gv, 32'h0000_0000);
		for (int v = 0; v < 16; v++) pchk(4'(v), 1'h0);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 3; i++) begin
			wr(offs[i], 32'hffff_ffff);
			rd(offs[i], 32'h070f_5037);
			wr(offs[i], 32'h0000_0000);
		end
		wr(12'h108, 32'hffff_ffff);
		rd(12'h108, 32'h0000_0000);
	endtask
	task automatic t_run;
		for (int u = 0; u < 14; u++) begin
			wr(offs[0], 32'h1 << ub[u]);
			@(posedge clk_sys);
			#1;
			`CHK(gv, 32'h1 << ub[u]);
			for (int v = 0; v < 16; v++) pchk(4'(v), v == u);
		end
	endtask
	task automatic t_modes;
		logic       au [6] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
		logic [1:0] md [6] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
		logic [31:0] ex [6];
		ex = '{32'h7, 32'h7, 32'h7, 32'hf0000, 32'h7005030, 32'h7005030};
		wr(offs[0], 32'h0000_0007);
		i_cpu.rmw_set(offs[1], 32'h000f_0000, ak);
		`CHK(ak, 1'h1);
		wr(offs[2], 32'h0700_5030);
		for (int i = 0; i < 6; i++) begin
			auto_gating_select = au[i];
			pwr_mode = pcg_mode_t'(md[i]);
			@(posedge clk_sys);
			#1;
			`CHK(gv, ex[i]);
		end
		pchk(4'hd, 1'h1);
		pchk(4'h0, 1'h0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'h0;
		auto_gating_select = 1'h0;
		pwr_mode = PCG_MODE_RUN;
		per_req = 1'h0;
		per_unit = 4'h0;
		repeat (4) @(posedge clk_sys);
		#1;
		rst_n = 1'h1;
		t_reset();
		t_regs();
		t_run();
		t_modes();
		// Mid-run reset must drop every enable and register
		rst_n = 1'h0;
		#1;
		`CHK(gv, 32'h0000_0000);
		@(posedge clk_sys);
		#1;
		rst_n = 1'h1;
		t_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire
